// ===== bench/csl_board.sv
// Board strap resistor model
`timescale 1ns/1ns
module csl_board
  import csl_pkg::*;
(
  // Wanted setting and pin levels
  input wire csl_strap_t set_i,
  output csl_strap_t pin_o
);
  // both pulled high ask for off
  assign pin_o = set_i;
endmodule

// ===== bench/csl_props_properties.sv
// Port assertions for the strap latch
`timescale 1ns/1ns
module csl_props
  import csl_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [2:0] mode_code_i,
  input wire logic [5:0] dplus_port_off_strap_i,
  input wire logic [5:0] dminus_port_off_strap_i,
  input wire logic hub_in_reset_o,
  input wire logic config_valid_o,
  input wire logic bridge_master_setting_o,
  input wire logic config_target_setting_o,
  input wire logic mode_reserved_o,
  input wire logic [5:0] dplus_off_o,
  input wire logic [5:0] dminus_off_o,
  input wire logic [5:0] usb2_port_off_o,
  input wire logic [5:0] ss_port_off_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Pins sit still three cycles around release
  sequence s_cap; $rose(config_valid_o); endsequence
  property p_cap;
    $rose(rstn_i) |-> hub_in_reset_o ##1 config_valid_o && !hub_in_reset_o;
  endproperty
  property p_mst; s_cap |->
    bridge_master_setting_o == ($past(mode_code_i, 3) == 3'h0); endproperty
  property p_tgt; s_cap |->
    config_target_setting_o == ($past(mode_code_i, 3) == 3'h1); endproperty
  property p_rsv; s_cap |->
    mode_reserved_o == ($past(mode_code_i, 3) > 3'h1); endproperty
  property p_dp; s_cap |->
    dplus_off_o == $past(dplus_port_off_strap_i, 3); endproperty
  property p_dm; s_cap |->
    dminus_off_o == $past(dminus_port_off_strap_i, 3); endproperty
  property p_both; s_cap |->
    usb2_port_off_o == (dplus_off_o & dminus_off_o); endproperty
  property p_ss; usb2_port_off_o == ss_port_off_o; endproperty
  property p_hold; config_valid_o [*2] |->
    $stable(dplus_off_o) && $stable(dminus_off_o) &&
    $stable(bridge_master_setting_o) && $stable(mode_reserved_o) &&
    $stable(config_target_setting_o); endproperty
  a_cap: assert property (p_cap)
    else $error("capture timing wrong");
  a_mst: assert property (p_mst)
    else $error("master mode wrong");
  a_tgt: assert property (p_tgt)
    else $error("target mode wrong");
  a_rsv: assert property (p_rsv)
    else $error("reserved mode wrong");
  a_dp: assert property (p_dp)
    else $error("dplus latch wrong");
  a_dm: assert property (p_dm)
    else $error("dminus latch wrong");
  a_both: assert property (p_both)
    else $error("port off wrong");
  a_ss: assert property (p_ss)
    else $error("superspeed off wrong");
  a_hold: assert property (p_hold)
    else $error("latched straps moved");
  c_cap: cover property (s_cap);
  c_rsv: cover property (s_cap ##0 mode_reserved_o);
  c_off: cover property (s_cap ##0 (|usb2_port_off_o));
endmodule

// ===== bench/csl_strap_latch_bench.sv
// Self-checking bench for the strap latch
`timescale 1ns/1ns
module csl_strap_latch_bench;
  import csl_pkg::*;
  logic clock_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0;
  logic [3:0] addr_i = '0;
  logic [31:0] wdata_i = '0, rdata_o;
  logic hub_in_reset_o, config_valid_o, mode_reserved_o;
  logic bridge_master_setting_o, config_target_setting_o;
  logic [5:0] dplus_off_o, dminus_off_o, usb2_port_off_o, ss_port_off_o;
  csl_strap_t strap = CSL_STRAP_RESET, pins;
  int fails = 0, cmp_count = 0;
  initial forever #20 clock_i = ~clock_i;
  csl_board u_board (.set_i(strap), .pin_o(pins));
  csl_strap_latch u_dut (.clock_i, .rstn_i, .mode_code_i(pins.mode),
    .dplus_port_off_strap_i(pins.dplus_port_off_strap),
    .dminus_port_off_strap_i(pins.dminus_port_off_strap),
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .hub_in_reset_o,
    .config_valid_o, .bridge_master_setting_o, .config_target_setting_o,
    .mode_reserved_o, .dplus_off_o, .dminus_off_o, .usb2_port_off_o,
    .ss_port_off_o);
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task boot(input csl_strap_t v);
    @(posedge clock_i);
    strap <= v;
    rstn_i <= 0;
    repeat (10) @(posedge clock_i);
    rstn_i <= 1;
    #1;
    chk({hub_in_reset_o, config_valid_o, usb2_port_off_o}, 8'h80);
    @(posedge clock_i);
    #1;
    chk({hub_in_reset_o, config_valid_o}, 2'h1);
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge clock_i);
    wr_i <= 0;
    rd_i <= 0;
    #1;
    if (!w) chk(rdata_o, d);
    @(posedge clock_i);
    #1;
    if (!w) chk(rdata_o, 32'h0000_0000);
  endtask
  task t_modes;
    for (int m = 0; m < 8; m++) begin
      boot('{m[2:0], 6'h00, 6'h00});
      chk(bridge_master_setting_o, m == 0);
      chk(config_target_setting_o, m == 1);
      chk(mode_reserved_o, m > 1);
      // Let the capture checks run before the next reset
      @(posedge clock_i);
    end
    $display("modes done");
  endtask
  task t_ports;
    boot('{3'h1, 6'h2a, 6'h33});
    chk(dplus_off_o, 6'h33);
    chk(dminus_off_o, 6'h2a);
    chk(usb2_port_off_o, 6'h22);
    chk(ss_port_off_o, 6'h22);
    // Pins move after capture, outputs must not
    @(posedge clock_i);
    strap <= ~strap;
    repeat (4) @(posedge clock_i);
    #1;
    chk(dplus_off_o, 6'h33);
    chk(usb2_port_off_o, 6'h22);
    boot(strap);
    chk(dplus_off_o, 6'h0c);
    chk(dminus_off_o, 6'h15);
    chk(usb2_port_off_o, 6'h04);
    chk(mode_reserved_o, 1'b1);
    $display("ports done");
  endtask
  task t_regs;
    bus(0, CSL_REG_STRAP, 32'h0000_654c);
    bus(0, CSL_REG_STATUS, 32'h0000_0409);
    bus(1, CSL_REG_CTRL, 32'h0000_0003);
    chk(ss_port_off_o, 6'h07);
    bus(1, CSL_REG_STRAP, 32'hffff_ffff);
    bus(0, CSL_REG_CTRL, 32'h0000_0003);
    bus(0, CSL_REG_STRAP, 32'h0000_654c);
    bus(0, 4'hc, 32'h0000_0000);
    $display("regs done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    t_modes();
    t_ports();
    t_regs();
    final_report();
  end
endmodule
bind csl_strap_latch csl_props u_props (.clock_i, .rstn_i, .mode_code_i,
  .dplus_port_off_strap_i, .dminus_port_off_strap_i, .hub_in_reset_o,
  .config_valid_o, .bridge_master_setting_o, .config_target_setting_o,
  .mode_reserved_o, .dplus_off_o, .dminus_off_o, .usb2_port_off_o,
  .ss_port_off_o);

// ===== hdl/csl_pkg.sv
// Shared constants and types for the strap latch and decode block
package csl_pkg;

  localparam int CSL_PORTS = 6;
  localparam int CSL_MODE_W = 3;
  localparam int CSL_ADDR_W = 4;
  localparam int CSL_DATA_W = 32;

  // Mode strap encodings, one per resistor option
  localparam logic [2:0] CSL_BRIDGE_MASTER_SETTING = 3'h0;
  localparam logic [2:0] CSL_CONFIG_TARGET_SETTING = 3'h1;

  // Register offsets
  localparam logic [3:0] CSL_REG_STRAP = 4'h0;
  localparam logic [3:0] CSL_REG_STATUS = 4'h4;
  localparam logic [3:0] CSL_REG_CTRL = 4'h8;

  // Strap image field positions
  localparam int CSL_STRAP_DPLUS_LSB = 0;
  localparam int CSL_STRAP_DMINUS_LSB = 6;
  localparam int CSL_STRAP_MODE_LSB = 12;

  // Status field positions
  localparam int CSL_ST_VALID_BIT = 0;
  localparam int CSL_ST_MASTER_BIT = 1;
  localparam int CSL_ST_TARGET_BIT = 2;
  localparam int CSL_ST_RSVD_BIT = 3;
  localparam int CSL_ST_PORT_OFF_LSB = 8;

  // Reset values
  localparam logic [5:0] CSL_CTRL_RESET = 6'h00;
  localparam logic [31:0] CSL_RDATA_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] mode;
    logic [5:0] dminus_port_off_strap;
    logic [5:0] dplus_port_off_strap;
  } csl_strap_t;

  localparam csl_strap_t CSL_STRAP_RESET = '{3'h0, 6'h00, 6'h00};

  typedef struct packed {
    logic bridge_master;
    logic config_target;
    logic reserved;
  } csl_mode_t;

endpackage

// ===== hdl/csl_strap_latch.sv
// Strap capture at reset release, hold, decode and register access
// Operation
// - Capture all straps when reset releases
// - Either reset source refreshes the capture; here rstn_i is the only reset, and it alone clears the capture flag
// - Encodings two to seven are reserved
// - First encoding: bridging bus master mode
// - Second encoding: configuration target mode
// - D+ strap one disables, zero enables
// - D- strap one disables, zero enables
// - Port off only when both straps high; here a set software mask bit also turns the port off
// - USB 2.0 off also turns SuperSpeed off
// - Low reset holds hub in reset
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
module csl_strap_latch
  import csl_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Strap pins
  input wire logic [2:0] mode_code_i,
  input wire logic [5:0] dplus_port_off_strap_i,
  input wire logic [5:0] dminus_port_off_strap_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Decoded configuration
  output logic hub_in_reset_o,
  output logic config_valid_o,
  output logic bridge_master_setting_o,
  output logic config_target_setting_o,
  output logic mode_reserved_o,
  output logic [5:0] dplus_off_o,
  output logic [5:0] dminus_off_o,
  output logic [5:0] usb2_port_off_o,
  output logic [5:0] ss_port_off_o
);

  //////////////////////////////////////////////////////////////////////

  function automatic csl_mode_t decode_mode(input logic [2:0] code);
    csl_mode_t m;
    m.bridge_master = (code == CSL_BRIDGE_MASTER_SETTING);
    m.config_target = (code == CSL_CONFIG_TARGET_SETTING);
    m.reserved = !(m.bridge_master || m.config_target);
    return m;
  endfunction

  //////////////////////////////////////////////////////////////////////

  csl_strap_t pins;
  csl_strap_t pins_sync;
  csl_strap_t latched;
  csl_strap_t next_latched;
  logic captured;
  logic next_captured;
  logic [5:0] sw_port_off;
  logic [5:0] next_sw_port_off;
  logic [31:0] next_rdata;
  // Next values of the registered outputs
  csl_mode_t next_mode;
  logic next_hub_in_reset;
  logic next_config_valid;
  logic next_bridge_master;
  logic next_config_target;
  logic next_mode_reserved;
  logic [5:0] next_dplus_off;
  logic [5:0] next_dminus_off;
  logic [5:0] next_strap_off;
  logic [5:0] next_port_off;

  assign pins.mode = mode_code_i;
  assign pins.dplus_port_off_strap = dplus_port_off_strap_i;
  assign pins.dminus_port_off_strap = dminus_port_off_strap_i;

  csl_sync u_sync (
    .clock_i(clock_i),
    .pins_i(pins),
    .sync_o(pins_sync)
  );

  //////////////////////////////////////////////////////////////////////

  always_comb begin
    next_latched = latched;
    next_captured = captured;
    // any reset clears the capture flag, so it reloads
    if (!captured) begin
      next_latched = pins_sync;
      next_captured = 1'b1;
    end
    // no other path writes the image
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      latched <= CSL_STRAP_RESET;
      captured <= 1'b0;
    end else begin
      latched <= next_latched;
      captured <= next_captured;
    end
  end

  //////////////////////////////////////////////////////////////////////

  // Outputs come from the next state through flops, so they
  // settle on the very edge that captures the straps.
  always_comb begin
    // Codes two to seven match no resistor and count as reserved
    // reserved codes decode to neither mode
    next_mode = decode_mode(next_latched.mode);
    next_config_valid = next_captured;
    next_hub_in_reset = !next_captured;
    next_bridge_master = next_captured && next_mode.bridge_master;
    next_config_target = next_captured && next_mode.config_target;
    next_mode_reserved = next_captured && next_mode.reserved;
  end

  always_ff @(posedge clock_i) begin
    // held reset shows the hub in reset
    if (!rstn_i) begin
      hub_in_reset_o <= 1'b1;
      config_valid_o <= 1'b0;
      bridge_master_setting_o <= 1'b0;
      config_target_setting_o <= 1'b0;
      mode_reserved_o <= 1'b0;
    end else begin
      hub_in_reset_o <= next_hub_in_reset;
      config_valid_o <= next_config_valid;
      bridge_master_setting_o <= next_bridge_master;
      config_target_setting_o <= next_config_target;
      mode_reserved_o <= next_mode_reserved;
    end
  end

  //////////////////////////////////////////////////////////////////////

  always_comb begin
    if (next_captured) begin
      next_dplus_off = next_latched.dplus_port_off_strap;
      next_dminus_off = next_latched.dminus_port_off_strap;
    end else begin
      next_dplus_off = 6'h00;
      next_dminus_off = 6'h00;
    end
    // both straps high needed, port n on bit n-1
    for (int p = 0; p < CSL_PORTS; p++) begin
      next_strap_off[p] = next_dplus_off[p] && next_dminus_off[p];
    end
    // Mask from software adds to the strap disables
    next_port_off = next_strap_off | next_sw_port_off;
    if (!next_captured) begin
      next_port_off = 6'h00;
    end
  end

  always_ff @(posedge clock_i) begin
    // No port reads as off until the straps are in
    if (!rstn_i) begin
      dplus_off_o <= 6'h00;
      dminus_off_o <= 6'h00;
      usb2_port_off_o <= 6'h00;
      ss_port_off_o <= 6'h00;
    end else begin
      dplus_off_o <= next_dplus_off;
      dminus_off_o <= next_dminus_off;
      usb2_port_off_o <= next_port_off;
      ss_port_off_o <= next_port_off;
    end
  end

  //////////////////////////////////////////////////////////////////////

  // Software can only add port disables, never undo a strap
  always_comb begin
    next_sw_port_off = sw_port_off;
    next_rdata = CSL_RDATA_RESET;
    if (wr_i && addr_i == CSL_REG_CTRL) begin
      next_sw_port_off = wdata_i[5:0];
    end
    if (rd_i) begin
      if (addr_i == CSL_REG_STRAP) begin
        next_rdata[CSL_STRAP_DPLUS_LSB +: 6] =
          latched.dplus_port_off_strap;
        next_rdata[CSL_STRAP_DMINUS_LSB +: 6] =
          latched.dminus_port_off_strap;
        next_rdata[CSL_STRAP_MODE_LSB +: 3] = latched.mode;
      end else if (addr_i == CSL_REG_STATUS) begin
        next_rdata[CSL_ST_VALID_BIT] = captured;
        next_rdata[CSL_ST_MASTER_BIT] = bridge_master_setting_o;
        next_rdata[CSL_ST_TARGET_BIT] = config_target_setting_o;
        next_rdata[CSL_ST_RSVD_BIT] = mode_reserved_o;
        next_rdata[CSL_ST_PORT_OFF_LSB +: 6] = usb2_port_off_o;
      end else if (addr_i == CSL_REG_CTRL) begin
        next_rdata[5:0] = sw_port_off;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      sw_port_off <= CSL_CTRL_RESET;
      rdata_o <= CSL_RDATA_RESET;
    end else begin
      sw_port_off <= next_sw_port_off;
      rdata_o <= next_rdata;
    end
  end

endmodule

// ===== hdl/csl_sync.sv
// Two-flop synchroniser for the strap pins
`timescale 1ns/1ns
module csl_sync
  import csl_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Pin side and synchronised side
  input wire csl_strap_t pins_i,
  output csl_strap_t sync_o
);

  csl_strap_t stage1;
  csl_strap_t stage2;

  // No reset: pins keep settling through reset, so the value is
  // already clean on the first edge after release.
  always_ff @(posedge clock_i) begin
    stage1 <= pins_i;
    stage2 <= stage1;
  end

  assign sync_o = stage2;

endmodule
